/* File: core/sagen_pkg.sv */
// Shared types and constants for the stack and address generation block.
// Assumes a 16-bit data path and byte-addressed data memory.
package sagen_pkg;

    // ************************************************************
    // Widths and fixed addresses
    // ************************************************************
    localparam int          SAGEN_DW          = 16;
    localparam int          SAGEN_FADDR_W     = 13;
    localparam int          SAGEN_LIT5_W      = 5;
    localparam int          SAGEN_LIT10_W     = 10;
    localparam logic [15:0] SAGEN_STACK_FLOOR = 16'h0800;
    localparam logic [15:0] SAGEN_WORD_STEP   = 16'h0002;
    localparam logic [15:0] SAGEN_SP_RESET    = 16'h0800;
    localparam logic [3:0]  SAGEN_SP_INDEX    = 4'hF;
    localparam logic [3:0]  SAGEN_DEFAULT_WORK_ALIAS_INDEX  = 4'h0;
    localparam logic [15:0] SAGEN_PC_MSB_MASK = 16'h007F;

    // ************************************************************
    // Addressing modes
    // ************************************************************
    typedef enum logic [8:0] {
        SAGEN_M_FILE    = 9'h001,
        SAGEN_M_DIRECT  = 9'h002,
        SAGEN_M_IND     = 9'h004,
        SAGEN_M_POST    = 9'h008,
        SAGEN_M_PRE     = 9'h010,
        SAGEN_M_REGOFS  = 9'h020,
        SAGEN_M_LITOFS  = 9'h040,
        SAGEN_M_LIT5    = 9'h080,
        SAGEN_M_LIT10   = 9'h100
    } sagen_mode_t;

    typedef enum logic [3:0] {
        SAGEN_S_NONE    = 4'h1,
        SAGEN_S_PUSH    = 4'h2,
        SAGEN_S_POP     = 4'h4,
        SAGEN_S_PCPUSH  = 4'h8
    } sagen_stk_t;

    // ************************************************************
    // Request and answer carriers
    // ************************************************************
    typedef struct packed {
        sagen_mode_t  mode;
        logic [3:0]   ptr_sel;
        logic [3:0]   ofs_sel;
        logic [15:0]  literal;
        logic [12:0]  faddr;
        logic         is_move;
        logic         signed_dec;
        logic [15:0]  step;
    } sagen_req_t;

    typedef struct packed {
        logic [15:0]  ea;
        logic [15:0]  operand;
        logic [3:0]   dest_default_work_alias;
        logic         ea_valid;
    } sagen_ans_t;

    typedef struct packed {
        logic         call_push;
        logic         exc_push;
        logic [15:0]  pc_msw;
        logic [7:0]   status_low_byte;
    } sagen_pc_t;

endpackage

/* File: core/sagen_ram_guard.sv */
// Secure RAM segment guard.
// Assumes region bounds and enables come from the system configuration.
`timescale 1ns/1ps
`default_nettype none
module sagen_ram_guard
    import sagen_pkg::*;
(
    // Address under check
    input  wire logic [15:0] ea,
    // Region setup
    input  wire logic        bs_en,
    input  wire logic [15:0] bs_lo,
    input  wire logic [15:0] bs_hi,
    input  wire logic        ss_en,
    input  wire logic [15:0] ss_lo,
    input  wire logic [15:0] ss_hi,
    // Running code segment
    input  wire logic        in_boot_seg,
    input  wire logic        in_secure_seg,
    // Verdict
    output logic             deny
);
    logic in_bs;
    logic in_ss;

    assign in_bs = bs_en && (ea >= bs_lo) && (ea <= bs_hi);
    assign in_ss = ss_en && (ea >= ss_lo) && (ea <= ss_hi);
    assign deny  = (in_bs && !in_boot_seg) || (in_ss && !in_secure_seg);
endmodule
`default_nettype wire

/* File: core/sagen_stack_check.sv */
// Stack limit and floor comparator.
// Assumes the pointer word arrives already formed for the current cycle.
`timescale 1ns/1ps
`default_nettype none
module sagen_stack_check
    import sagen_pkg::*;
(
    // Address formed through the stack pointer
    input  wire logic        sp_used,
    input  wire logic        is_push,
    input  wire logic [15:0] sp_ea,
    input  wire logic [15:0] limit,
    // Trap request
    output logic             stack_err
);
    logic over;
    logic under;

    // Push at the limit itself is allowed; only the next one traps
    assign over      = is_push && (sp_ea > limit);
    assign under     = sp_ea < SAGEN_STACK_FLOOR;
    assign stack_err = sp_used && (over || under);
endmodule
`default_nettype wire

/* File: core/sagen_top.sv */
// Stack and data address generation for a 16-bit signal-controller core.
// Assumes decode and data memory run on mclk and obey the ordering note below.
//
// Overview of operation
// - Stack pointer register always addresses the first free word, growing upward.
// - Pop pre-decrements the stack pointer; push post-increments it.
// - Call pushes the counter's top part zero-extended, top bit clear.
// - Exception push joins the low status byte onto the counter's top part.
// - Limit register has no reset value; bit zero always reads and acts zero.
// - Only push addresses formed through the stack pointer are compared with the limit.
// - Push at the limit is fine; the following push traps.
// - Stack pointer address below 0x0800 raises a stack error trap.
// - Boot secure RAM region is reachable only from boot segment code.
// - General secure RAM region is reachable only from secure segment code.
// - File register instructions use a 13-bit address into the near space.
// - File register ops default to register zero; result to file or that register.
// - Move instructions may address the whole data space.
// - Three-operand ops: first operand direct register; second register or 5-bit literal.
// - Arithmetic supports 5 or 10 bit literals and all indirect modes.
// - File register direct mode takes the address from the instruction word.
// - Post-modified: pointer forms the address, then steps by a constant.
// - Pre-modified: pointer steps by a signed constant, then forms the address.
// - Register offset: address is pointer plus offset register.
// - Literal offset: address is pointer plus instruction literal.
`timescale 1ns/1ps
`default_nettype none
module sagen_top
    import sagen_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Address request from decode
    input  wire logic        req_valid,
    input  wire sagen_req_t  req,
    input  wire sagen_stk_t  stk_op,
    input  wire logic [15:0] push_data,
    // Program counter push
    input  wire sagen_pc_t   pc_push,
    // Register file writes from execute
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_sel,
    input  wire logic [15:0] wr_data,
    // Limit register write
    input  wire logic        limit_wr,
    input  wire logic [15:0] limit_data,
    // Secure RAM setup
    input  wire logic        bs_en,
    input  wire logic [15:0] bs_lo,
    input  wire logic [15:0] bs_hi,
    input  wire logic        ss_en,
    input  wire logic [15:0] ss_lo,
    input  wire logic [15:0] ss_hi,
    input  wire logic        in_boot_seg,
    input  wire logic        in_secure_seg,
    // Answer to data memory and exception logic
    output sagen_ans_t       ans_q,
    output logic [15:0]      push_word_q,
    output logic             push_we_q,
    output logic             stack_trap_q,
    output logic             ram_deny_q,
    output logic [15:0]      stack_pointer_q,
    output logic [15:0]      stack_limit_q
);

    // ************************************************************
    // Working register file
    // ************************************************************
    logic [15:0] work_q [16];
    logic [15:0] ptr_val;
    logic [15:0] ofs_val;
    logic [15:0] ea_d;
    logic [15:0] ptr_new;
    logic        ptr_wb;
    logic        sp_used;
    logic        is_push;
    logic        stack_err;
    logic        deny;
    logic [15:0] stack_limit_reg;
    logic [15:0] stk_ea;
    logic [15:0] sp_next;
    logic [15:0] pc_word;
    logic        limit_wr_q;

    assign ptr_val = work_q[req.ptr_sel];
    assign ofs_val = work_q[req.ofs_sel];

    // ************************************************************
    // Effective address forming
    // ************************************************************
    always_comb begin
        ea_d    = ptr_val;
        ptr_new = ptr_val;
        ptr_wb  = 1'b0;
        unique case (req.mode)
            SAGEN_M_FILE: begin
                // Only moves reach past the near region
                ea_d = req.is_move ? req.literal : {3'h0, req.faddr};
            end
            SAGEN_M_DIRECT: ea_d = 16'h0000;
            SAGEN_M_IND:    ea_d = ptr_val;
            SAGEN_M_POST: begin
                ea_d    = ptr_val;
                ptr_new = req.signed_dec ? ptr_val - req.step : ptr_val + req.step;
                ptr_wb  = 1'b1;
            end
            SAGEN_M_PRE: begin
                ptr_new = req.signed_dec ? ptr_val - req.step : ptr_val + req.step;
                ea_d    = ptr_new;
                ptr_wb  = 1'b1;
            end
            SAGEN_M_REGOFS: ea_d = ptr_val + ofs_val;
            SAGEN_M_LITOFS: ea_d = ptr_val + req.literal;
            SAGEN_M_LIT5:   ea_d = {11'h000, req.literal[SAGEN_LIT5_W-1:0]};
            SAGEN_M_LIT10:  ea_d = {6'h00, req.literal[SAGEN_LIT10_W-1:0]};
            default: begin
                ea_d    = ptr_val;
                ptr_new = ptr_val;
                ptr_wb  = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Stack operations
    // ************************************************************
    always_comb begin
        stk_ea  = work_q[SAGEN_SP_INDEX];
        sp_next = work_q[SAGEN_SP_INDEX];
        unique case (stk_op)
            SAGEN_S_NONE: begin
                stk_ea  = work_q[SAGEN_SP_INDEX];
                sp_next = work_q[SAGEN_SP_INDEX];
            end
            SAGEN_S_PUSH, SAGEN_S_PCPUSH: begin
                stk_ea  = work_q[SAGEN_SP_INDEX];
                sp_next = work_q[SAGEN_SP_INDEX] + SAGEN_WORD_STEP;
            end
            SAGEN_S_POP: begin
                sp_next = work_q[SAGEN_SP_INDEX] - SAGEN_WORD_STEP;
                stk_ea  = sp_next;
            end
            default: begin
                stk_ea  = work_q[SAGEN_SP_INDEX];
                sp_next = work_q[SAGEN_SP_INDEX];
            end
        endcase
    end

    // Exception push carries status; a call push keeps the top bit clear
    assign pc_word = pc_push.exc_push ? {pc_push.status_low_byte, pc_push.pc_msw[7:0]}
                                      : (pc_push.pc_msw & SAGEN_PC_MSB_MASK);

    assign is_push = req_valid && ((stk_op == SAGEN_S_PUSH) || (stk_op == SAGEN_S_PCPUSH));
    // Register direct reads the pointer as data and forms no address
    assign sp_used = req_valid && ((stk_op != SAGEN_S_NONE)
                     || (req.ptr_sel == SAGEN_SP_INDEX && req.mode != SAGEN_M_FILE
                         && req.mode != SAGEN_M_DIRECT
                         && req.mode != SAGEN_M_LIT5 && req.mode != SAGEN_M_LIT10));

    sagen_stack_check u_check (
        .sp_used   (sp_used),
        .is_push   (is_push),
        .sp_ea     ((stk_op != SAGEN_S_NONE) ? stk_ea : ea_d),
        .limit     (stack_limit_reg),
        .stack_err (stack_err)
    );

    sagen_ram_guard u_guard (
        .ea            ((stk_op != SAGEN_S_NONE) ? stk_ea : ea_d),
        .bs_en         (bs_en),
        .bs_lo         (bs_lo),
        .bs_hi         (bs_hi),
        .ss_en         (ss_en),
        .ss_lo         (ss_lo),
        .ss_hi         (ss_hi),
        .in_boot_seg   (in_boot_seg),
        .in_secure_seg (in_secure_seg),
        .deny          (deny)
    );

    // ************************************************************
    // Register file update
    // ************************************************************
    // Pointer write-back wins over an execute write to the same register
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_work
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    work_q[gi] <= (gi == 15) ? SAGEN_SP_RESET : 16'h0000;
                end else if (gi == 15 && req_valid && stk_op != SAGEN_S_NONE) begin
                    work_q[gi] <= sp_next & ~16'h0001;
                end else if (req_valid && ptr_wb && req.ptr_sel == 4'(gi)) begin
                    work_q[gi] <= ptr_new;
                end else if (wr_en && wr_sel == 4'(gi)) begin
                    work_q[gi] <= (gi == 15) ? (wr_data & ~16'h0001) : wr_data;
                end
            end
        end
    endgenerate

    // Limit has no reset: its content is undefined until software writes it
    always_ff @(posedge mclk) begin
        if (limit_wr) begin
            stack_limit_reg <= limit_data & ~16'h0001;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            limit_wr_q <= 1'b0;
        end else begin
            limit_wr_q <= limit_wr;
        end
    end

    // ************************************************************
    // Answer registers
    // ************************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ans_q        <= '0;
            push_word_q  <= 16'h0000;
            push_we_q    <= 1'b0;
            stack_trap_q <= 1'b0;
            ram_deny_q   <= 1'b0;
        end else begin
            ans_q.ea_valid  <= req_valid;
            ans_q.ea        <= (stk_op != SAGEN_S_NONE) ? stk_ea : ea_d;
            ans_q.operand   <= (req.mode == SAGEN_M_DIRECT) ? ptr_val : ea_d;
            ans_q.dest_default_work_alias <= (req.mode == SAGEN_M_FILE) ? SAGEN_DEFAULT_WORK_ALIAS_INDEX : req.ptr_sel;
            push_we_q       <= is_push;
            push_word_q     <= (stk_op == SAGEN_S_PCPUSH) ? pc_word : push_data;
            stack_trap_q    <= stack_err;
            ram_deny_q      <= req_valid && deny;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stack_pointer_q <= SAGEN_SP_RESET;
            stack_limit_q   <= 16'h0000;
        end else begin
            stack_pointer_q <= work_q[SAGEN_SP_INDEX];
            stack_limit_q   <= stack_limit_reg;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_push_step;
        @(posedge mclk) disable iff (reset)
        (req_valid && stk_op == SAGEN_S_PUSH) |=> (work_q[15] == $past(work_q[15]) + SAGEN_WORD_STEP);
    endproperty
    a_push_step: assert property (p_push_step) else $error("push did not step pointer up");

    property p_pop_ea;
        @(posedge mclk) disable iff (reset)
        (req_valid && stk_op == SAGEN_S_POP) |=> (ans_q.ea == $past(work_q[15]) - SAGEN_WORD_STEP);
    endproperty
    a_pop_ea: assert property (p_pop_ea) else $error("pop address not pre-decremented");

    property p_call_msb;
        @(posedge mclk) disable iff (reset)
        (req_valid && stk_op == SAGEN_S_PCPUSH && pc_push.call_push && !pc_push.exc_push) |=> !push_word_q[15];
    endproperty
    a_call_msb: assert property (p_call_msb) else $error("call push top bit set");

    property p_limit_lsb;
        @(posedge mclk) disable iff (reset)
        limit_wr_q |-> !stack_limit_reg[0];
    endproperty
    a_limit_lsb: assert property (p_limit_lsb) else $error("limit bit zero not clear");

    property p_floor;
        @(posedge mclk) disable iff (reset)
        (req_valid && stk_op == SAGEN_S_POP && stk_ea < SAGEN_STACK_FLOOR) |=> stack_trap_q;
    endproperty
    a_floor: assert property (p_floor) else $error("underflow not trapped");

    property p_at_limit;
        @(posedge mclk) disable iff (reset)
        (is_push && stk_ea == stack_limit_reg && stk_ea >= SAGEN_STACK_FLOOR) |=> !stack_trap_q;
    endproperty
    a_at_limit: assert property (p_at_limit) else $error("push at limit trapped");

    property p_plain_ind;
        @(posedge mclk) disable iff (reset)
        (req_valid && req.mode == SAGEN_M_IND && stk_op == SAGEN_S_NONE && !wr_en)
            |=> (ans_q.ea == $past(ptr_val)) && (work_q[$past(req.ptr_sel)] == $past(ptr_val));
    endproperty
    a_plain_ind: assert property (p_plain_ind) else $error("plain indirect altered pointer");

    property p_boot_guard;
        @(posedge mclk) disable iff (reset)
        (req_valid && bs_en && !in_boot_seg
            && ea_d >= bs_lo && ea_d <= bs_hi && stk_op == SAGEN_S_NONE) |=> ram_deny_q;
    endproperty
    a_boot_guard: assert property (p_boot_guard) else $error("boot region not guarded");

    property p_regofs;
        @(posedge mclk) disable iff (reset)
        (req_valid && req.mode == SAGEN_M_REGOFS && stk_op == SAGEN_S_NONE)
            |=> ans_q.ea == $past(ptr_val) + $past(ofs_val);
    endproperty
    a_regofs: assert property (p_regofs) else $error("indexed address wrong");

endmodule
`default_nettype wire

/* File: tb/sagen_mem_model.sv */
// Data memory model on the far side of the generator.
// Assumes stack writes come as one-cycle strobes on mclk.
`timescale 1ns/1ps
`default_nettype none
module sagen_mem_model
    import sagen_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Stack write
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    // Observation
    output logic [15:0]      last_addr,
    output logic [15:0]      last_word,
    output logic             misalign
);
    // Sticky, so one odd write is still seen at the end of the run
    initial misalign = 1'b0;
    always @(posedge mclk) begin
        if (we) begin
            last_addr <= addr;
            last_word <= wdata;
            misalign  <= misalign | addr[0];
        end
    end
endmodule
`default_nettype wire

/* File: tb/sagen_top_tb_top.sv */
// Self-checking bench for the stack and address generator.
// Assumes the one-cycle answer and reset values of the hand-over.
`timescale 1ns/1ps
`default_nettype none
module sagen_top_tb_top
    import sagen_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        mclk = 1'b0, reset = 1'b1, req_valid = 1'b0, wr_en = 1'b0, limit_wr = 1'b0;
    logic        bs_en = 1'b0, ss_en = 1'b0, in_boot_seg = 1'b0, in_secure_seg = 1'b0;
    logic [3:0]  wr_sel = 4'h0;
    logic [15:0] push_data = 16'h0000, wr_data = 16'h0000, limit_data = 16'h0000;
    logic [15:0] bs_lo = 16'h0000, bs_hi = 16'h0000, ss_lo = 16'h0000, ss_hi = 16'h0000;
    sagen_req_t  req = '0, nr = '0;
    sagen_stk_t  stk_op = SAGEN_S_NONE;
    sagen_pc_t   pc_push = '0;
    sagen_ans_t  ans_q;
    logic [15:0] push_word_q, stack_pointer_q, stack_limit_q, last_addr, last_word;
    logic        push_we_q, stack_trap_q, ram_deny_q, misalign;
    int          n_fail = 0, check_count = 0;

    always #12.5 mclk = ~mclk;

    sagen_top dut (
        .mclk(mclk), .reset(reset), .req_valid(req_valid), .req(req), .stk_op(stk_op),
        .push_data(push_data), .pc_push(pc_push), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
        .limit_wr(limit_wr), .limit_data(limit_data), .bs_en(bs_en), .bs_lo(bs_lo), .bs_hi(bs_hi),
        .ss_en(ss_en), .ss_lo(ss_lo), .ss_hi(ss_hi), .in_boot_seg(in_boot_seg),
        .in_secure_seg(in_secure_seg), .ans_q(ans_q), .push_word_q(push_word_q), .push_we_q(push_we_q),
        .stack_trap_q(stack_trap_q), .ram_deny_q(ram_deny_q), .stack_pointer_q(stack_pointer_q),
        .stack_limit_q(stack_limit_q)
    );

    sagen_mem_model mem (
        .mclk(mclk), .we(push_we_q), .addr(ans_q.ea), .wdata(push_word_q),
        .last_addr(last_addr), .last_word(last_word), .misalign(misalign)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chkb(input string nm, input logic exp, input logic got);
        chk(nm, {15'h0000, exp}, {15'h0000, got});
    endtask

    // Answers stand one cycle, so they are read 1 ns after the taking edge
    task automatic go(input sagen_stk_t s, input logic [15:0] d);
        @(posedge mclk);
        req_valid <= 1'b1;
        req       <= nr;
        stk_op    <= s;
        push_data <= d;
        @(posedge mclk);
        req_valid <= 1'b0;
        stk_op    <= SAGEN_S_NONE;
        #1;
    endtask

    task automatic default_work_alias(input logic [3:0] n, input logic [15:0] d);
        @(posedge mclk);
        wr_en   <= 1'b1;
        wr_sel  <= n;
        wr_data <= d;
        @(posedge mclk);
        wr_en   <= 1'b0;
    endtask

    // Next request starts an edge later, so no pointer read follows directly
    task automatic lim(input logic [15:0] d);
        @(posedge mclk);
        limit_wr   <= 1'b1;
        limit_data <= d;
        @(posedge mclk);
        limit_wr   <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] n, input logic [15:0] exp);
        nr.mode    = SAGEN_M_DIRECT;
        nr.ptr_sel = n;
        go(SAGEN_S_NONE, 16'h0000);
        chk(nm, exp, ans_q.operand);
    endtask

    task automatic sp_chk(input logic [15:0] exp);
        @(posedge mclk);
        #1;
        chk("sp copy", exp, stack_pointer_q);
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_stack;
        lim(16'h0805);
        sp_chk(SAGEN_SP_RESET);
        chk("limit", 16'h0804, stack_limit_q);
        nr = '0;
        nr.mode = SAGEN_M_IND;
        for (int i = 0; i < 4; i++) begin
            go(SAGEN_S_PUSH, 16'hA500 + 16'(i));
            chk("push ea", 16'h0800 + 16'(2 * i), ans_q.ea);
            chk("push word", 16'hA500 + 16'(i), push_word_q);
            chkb("push we", 1'b1, push_we_q);
            chkb("overflow", i == 3, stack_trap_q);
        end
        sp_chk(16'h0808);
        chkb("push we end", 1'b0, push_we_q);
        chkb("valid end", 1'b0, ans_q.ea_valid);
        chk("mem addr", 16'h0806, last_addr);
        chk("mem word", 16'hA503, last_word);
        go(SAGEN_S_POP, 16'h0000);
        chk("pop ea", 16'h0806, ans_q.ea);
        chkb("pop trap", 1'b0, stack_trap_q);
        default_work_alias(4'hF, 16'h0801);
        sp_chk(16'h0800);
        go(SAGEN_S_POP, 16'h0000);
        chk("low pop ea", 16'h07FE, ans_q.ea);
        chkb("underflow", 1'b1, stack_trap_q);
        default_work_alias(4'hF, 16'h0800);
        nr.mode = SAGEN_M_PRE;
        nr.ptr_sel = SAGEN_SP_INDEX;
        nr.signed_dec = 1'b1;
        nr.step = SAGEN_WORD_STEP;
        go(SAGEN_S_NONE, 16'h0000);
        chk("sp pre ea", 16'h07FE, ans_q.ea);
        chkb("sp ea trap", 1'b1, stack_trap_q);
        $display("test stack done");
    endtask

    task automatic t_pc;
        lim(16'hFFFE);
        default_work_alias(4'hF, 16'h0900);
        nr = '0;
        nr.mode = SAGEN_M_IND;
        @(posedge mclk);
        pc_push <= '{call_push: 1'b1, exc_push: 1'b0, pc_msw: 16'hFFFF, status_low_byte: 8'h5A};
        go(SAGEN_S_PCPUSH, 16'h0000);
        chk("call word", 16'h007F, push_word_q);
        chk("call ea", 16'h0900, ans_q.ea);
        @(posedge mclk);
        pc_push <= '{call_push: 1'b0, exc_push: 1'b1, pc_msw: 16'h12C3, status_low_byte: 8'h5A};
        go(SAGEN_S_PCPUSH, 16'h0000);
        chk("exc word", 16'h5AC3, push_word_q);
        $display("test pc push done");
    endtask

    task automatic t_modes;
        default_work_alias(4'h3, 16'h1230);
        default_work_alias(4'h4, 16'h0010);
        nr = '0;
        nr.ofs_sel = 4'h4;
        nr.literal = 16'h0100;
        nr.step = SAGEN_WORD_STEP;
        rd_chk("direct", 4'h3, 16'h1230);
        nr.mode = SAGEN_M_IND;
        go(SAGEN_S_NONE, 16'h0000);
        chk("ind ea", 16'h1230, ans_q.ea);
        chkb("ind valid", 1'b1, ans_q.ea_valid);
        rd_chk("ind keeps", 4'h3, 16'h1230);
        nr.mode = SAGEN_M_POST;
        go(SAGEN_S_NONE, 16'h0000);
        chk("post ea", 16'h1230, ans_q.ea);
        rd_chk("post step", 4'h3, 16'h1232);
        nr.mode = SAGEN_M_PRE;
        nr.signed_dec = 1'b1;
        nr.step = 16'h0004;
        go(SAGEN_S_NONE, 16'h0000);
        chk("pre ea", 16'h122E, ans_q.ea);
        nr.mode = SAGEN_M_REGOFS;
        go(SAGEN_S_NONE, 16'h0000);
        chk("regofs ea", 16'h123E, ans_q.ea);
        nr.mode = SAGEN_M_LITOFS;
        go(SAGEN_S_NONE, 16'h0000);
        chk("litofs ea", 16'h132E, ans_q.ea);
        rd_chk("ofs keeps", 4'h3, 16'h122E);
        nr = '0;
        nr.mode = SAGEN_M_FILE;
        nr.faddr = 13'h1FFF;
        nr.literal = 16'hABCE;
        go(SAGEN_S_NONE, 16'h0000);
        chk("file ea", 16'h1FFF, ans_q.ea);
        chk("file dest", 16'h0000, {12'h000, ans_q.dest_default_work_alias});
        nr.is_move = 1'b1;
        go(SAGEN_S_NONE, 16'h0000);
        chk("move ea", 16'hABCE, ans_q.ea);
        nr.literal = 16'hFFFF;
        nr.mode = SAGEN_M_LIT5;
        go(SAGEN_S_NONE, 16'h0000);
        chk("lit5", 16'h001F, ans_q.operand);
        nr.mode = SAGEN_M_LIT10;
        go(SAGEN_S_NONE, 16'h0000);
        chk("lit10", 16'h03FF, ans_q.operand);
        rd_chk("sp direct", SAGEN_SP_INDEX, SAGEN_SP_RESET);
        chkb("direct no trap", 1'b0, stack_trap_q);
        $display("test modes done");
    endtask

    // Mid-run reset: pointer returns to its start, the limit keeps its content
    task automatic t_reset;
        @(posedge mclk);
        reset <= 1'b1;
        @(posedge mclk);
        #1;
        chk("rst sp", SAGEN_SP_RESET, stack_pointer_q);
        chk("rst limit copy", 16'h0000, stack_limit_q);
        chkb("rst we", 1'b0, push_we_q);
        chkb("rst trap", 1'b0, stack_trap_q);
        @(posedge mclk);
        reset <= 1'b0;
        sp_chk(SAGEN_SP_RESET);
        chk("kept limit", 16'hFFFE, stack_limit_q);
        $display("test reset done");
    endtask

    task automatic t_secure;
        default_work_alias(4'h5, 16'h1000);
        default_work_alias(4'h6, 16'h20FF);
        @(posedge mclk);
        bs_en <= 1'b1;
        bs_lo <= 16'h1000;
        bs_hi <= 16'h10FF;
        ss_en <= 1'b1;
        ss_lo <= 16'h2000;
        ss_hi <= 16'h20FF;
        nr = '0;
        nr.mode = SAGEN_M_IND;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            in_boot_seg   <= i[0];
            in_secure_seg <= i[1];
            nr.ptr_sel = 4'h5;
            go(SAGEN_S_NONE, 16'h0000);
            chkb("boot deny", !i[0], ram_deny_q);
            nr.ptr_sel = 4'h6;
            go(SAGEN_S_NONE, 16'h0000);
            chkb("secure deny", !i[1], ram_deny_q);
        end
        @(posedge mclk);
        bs_en       <= 1'b0;
        in_boot_seg <= 1'b0;
        nr.ptr_sel = 4'h5;
        go(SAGEN_S_NONE, 16'h0000);
        chkb("boot off", 1'b0, ram_deny_q);
        $display("test secure done");
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        t_stack;
        t_pc;
        t_reset;
        t_modes;
        t_secure;
        chkb("misalign", 1'b0, misalign);
        give_verdict;
    end

    // Bounds the whole run in case the sequence stalls
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        $display("CHECK FAILED watchdog expected end seen hang");
        give_verdict;
    end
endmodule
`default_nettype wire
